//--- rcd_decimator.sv
// resampling second-order comb stage feeding a fifth-order comb decimator
// How it works
// RQ1 - resample decimation register holds factor minus one, twelve bits
// RQ2 - resample interpolation register holds factor minus one, nine bits
// RQ3 - scale bits 4..0 give the strong-signal scale, attenuator included
// RQ4 - scale bits 9..5 give the weak-signal scale, computed value only
// RQ5 - scale bit 10 makes each exponent step 12 dB instead of 6 dB
// RQ6 - scale bit 11 inverts the external exponent before use
// RQ7 - ratio 1/1 passes data unfiltered but still scaled
// RQ8 - software keeps fifth stage input rate within clock over channel count
// RQ9 - fifth stage decimation accepts every factor from 2 to 32
// RQ10 - five integrator and comb sections, output scaled by two to minus scale plus five
// RQ11 - fifth stage scale runs 0 to 20, each step 6 dB more attenuation
// RQ12 - software picks the smallest fifth stage scale that avoids overflow
// RQ13 - fifth stage emits one sample per decimation-factor input samples
// RQ14 - fifth stage input is the resampling stage output stream
// RQ15 - resampling stage takes a sample every clock, any mode
// RQ16 - software programs the simplest interpolation to decimation ratio
// RQ17 - interpolation 1..512, decimation 1..4096, ratio at most one
// RQ18 - input shifted right by exponent plus scale modulo eight, inverted form optional
// RQ19 - software keeps summed resample scale below 32
// RQ20 - each stage marks new samples with a one-cycle valid strobe
// RQ21 - in-phase and quadrature paths share rate and scale settings
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module rcd_decimator
	import rcd_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire rcd_in_iq_t in_sample,
	input wire logic [2:0] in_exp,
	input wire logic in_valid,
	output rcd_out_iq_t out_sample,
	output logic out_valid
);
	logic [11:0] rs_dec_ff;
	logic [8:0] rs_int_ff;
	logic [11:0] rs_scl_ff;
	logic [5:0] f5_dec_ff;
	logic [4:0] f5_scl_ff;
	logic strong_sel_ff;
	logic [15:0] out_cnt_ff;
	logic aw_have_ff;
	logic w_have_ff;
	logic [9:0] aw_idx_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic do_wr;
	logic [31:0] wr_word;
	logic [31:0] old_word;
	logic [31:0] rd_word;
	logic rd_hit;
	logic wr_hit;

	assign s_axi_awready = !aw_have_ff && !bvalid_ff;
	assign s_axi_wready = !w_have_ff && !bvalid_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign do_wr = aw_have_ff && w_have_ff && !bvalid_ff;

	// register contents as a word, shared by read mux and byte-lane merge
	function automatic logic [31:0] reg_word(input logic [9:0] idx);
		logic [31:0] v;
		v = 32'h0;
		unique case (idx)
			RCD_IDX_RS_DEC: v = {20'h0, rs_dec_ff};
			RCD_IDX_RS_INT: v = {23'h0, rs_int_ff};
			RCD_IDX_RS_SCL: v = {20'h0, rs_scl_ff};
			RCD_IDX_F5_DEC: v = {26'h0, f5_dec_ff};
			RCD_IDX_F5_SCL: v = {27'h0, f5_scl_ff};
			RCD_IDX_CTRL: v = {31'h0, strong_sel_ff};
			RCD_IDX_STAT: v = {16'h0, out_cnt_ff};
			default: v = 32'h0;
		endcase
		return v;
	endfunction

	function automatic logic is_mapped(input logic [9:0] idx);
		return idx inside {RCD_IDX_RS_DEC, RCD_IDX_RS_INT, RCD_IDX_RS_SCL,
			RCD_IDX_F5_DEC, RCD_IDX_F5_SCL, RCD_IDX_CTRL, RCD_IDX_STAT};
	endfunction

	always_comb
	begin
		old_word = reg_word(aw_idx_ff);
		for (int b = 0; b < 4; b++)
		begin
			wr_word[8*b +: 8] = w_strb_ff[b] ? w_data_ff[8*b +: 8] : old_word[8*b +: 8];
		end
		wr_hit = is_mapped(aw_idx_ff);
		rd_word = reg_word(s_axi_araddr[11:2]);
		rd_hit = is_mapped(s_axi_araddr[11:2]);
	end

	// write address and data captured in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_ff <= 1'b0;
			w_have_ff <= 1'b0;
			aw_idx_ff <= 10'h0;
			w_data_ff <= 32'h0;
			w_strb_ff <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_ff <= 1'b1;
				aw_idx_ff <= s_axi_awaddr[11:2];
			end
			else if (do_wr)
			begin
				aw_have_ff <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end
			else if (do_wr)
			begin
				w_have_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_ff <= 1'b0;
			bresp_ff <= RCD_RESP_OKAY;
		end
		else if (do_wr)
		begin
			bvalid_ff <= 1'b1;
			bresp_ff <= wr_hit ? RCD_RESP_OKAY : RCD_RESP_SLVERR;
		end
		else if (s_axi_bready)
		begin
			bvalid_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rs_dec_ff <= RCD_RS_DEC_RST;
			rs_int_ff <= RCD_RS_INT_RST;
			rs_scl_ff <= RCD_RS_SCL_RST;
			f5_dec_ff <= RCD_F5_DEC_RST;
			f5_scl_ff <= RCD_F5_SCL_RST;
			strong_sel_ff <= 1'b0;
		end
		else if (do_wr)
		begin
			unique case (aw_idx_ff)
				RCD_IDX_RS_DEC: rs_dec_ff <= wr_word[RCD_DEC_W-1:0]; // RQ1
				RCD_IDX_RS_INT: rs_int_ff <= wr_word[RCD_INT_W-1:0]; // RQ2
				RCD_IDX_RS_SCL: rs_scl_ff <= wr_word[RCD_SCL_W-1:0];
				RCD_IDX_F5_DEC: f5_dec_ff <= wr_word[RCD_F5D_W-1:0];
				RCD_IDX_F5_SCL: f5_scl_ff <= wr_word[RCD_F5S_W-1:0];
				RCD_IDX_CTRL: strong_sel_ff <= wr_word[0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0;
			rresp_ff <= RCD_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_ff <= 1'b1;
			rdata_ff <= rd_word;
			rresp_ff <= rd_hit ? RCD_RESP_OKAY : RCD_RESP_SLVERR;
		end
		else if (s_axi_rready)
		begin
			rvalid_ff <= 1'b0;
		end
	end

	// shared settings for both paths
	logic bypass;
	logic [4:0] scl_sel;
	logic [2:0] exp_eff;
	logic [3:0] exp_wt;
	logic [5:0] scl_total;
	logic [2:0] in_shift;
	logic [4:0] coarse_shift;
	logic [5:0] f5_m;
	logic [4:0] f5_s;
	logic [5:0] f5_shift;
	logic [12:0] phase_sum;
	logic emit;
	logic [11:0] phase_ff;
	logic rs_valid_ff;
	logic [5:0] f5_cnt_ff;
	logic f5_dump;

	assign bypass = (rs_dec_ff == 12'h0) && (rs_int_ff == 9'h0); // RQ7
	assign scl_sel = strong_sel_ff ? rs_scl_ff[RCD_STRONG_LSB +: 5] // RQ3
		: rs_scl_ff[RCD_WEAK_LSB +: 5]; // RQ4
	assign exp_eff = rs_scl_ff[RCD_INV_BIT] ? RCD_EXP_MAX - in_exp : in_exp; // RQ6
	assign exp_wt = rs_scl_ff[RCD_WEIGHT_BIT] ? {exp_eff, 1'b0} : {1'b0, exp_eff}; // RQ5
	assign scl_total = {2'b00, exp_wt} + {1'b0, scl_sel};
	assign in_shift = scl_total[2:0]; // RQ18
	assign coarse_shift = {scl_sel[4:3], 3'b000};
	assign f5_m = (f5_dec_ff < RCD_F5_DEC_MIN) ? RCD_F5_DEC_MIN
		: (f5_dec_ff > RCD_F5_DEC_MAX) ? RCD_F5_DEC_MAX : f5_dec_ff; // RQ9
	assign f5_s = (f5_scl_ff > RCD_F5_SCL_MAX) ? RCD_F5_SCL_MAX : f5_scl_ff; // RQ11
	assign f5_shift = {1'b0, f5_s} + RCD_F5_SHIFT_OFS; // RQ10
	// phase step of L per input; L not above M gives at most one output per input
	assign phase_sum = {1'b0, phase_ff} + {4'h0, rs_int_ff} + 13'h1; // RQ17
	assign emit = phase_sum >= ({1'b0, rs_dec_ff} + 13'h1);
	assign f5_dump = rs_valid_ff && (f5_cnt_ff == f5_m - 6'h1); // RQ13

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			phase_ff <= 12'h0;
			rs_valid_ff <= 1'b0;
		end
		else
		begin
			rs_valid_ff <= in_valid && (bypass || emit); // RQ20
			if (in_valid && !bypass)
			begin
				phase_ff <= emit ? 12'(phase_sum - {1'b0, rs_dec_ff} - 13'h1)
					: phase_sum[11:0]; // RQ2
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			f5_cnt_ff <= 6'h0;
			out_valid <= 1'b0;
			out_cnt_ff <= 16'h0;
		end
		else
		begin
			out_valid <= f5_dump; // RQ20
			if (f5_dump)
			begin
				out_cnt_ff <= out_cnt_ff + 16'h1;
			end
			if (rs_valid_ff) // RQ14
			begin
				f5_cnt_ff <= f5_dump || (f5_cnt_ff >= f5_m) ? 6'h0 : f5_cnt_ff + 6'h1;
			end
		end
	end

	logic signed [RCD_IN_W-1:0] scaled [RCD_PATHS];
	logic signed [RCD_RS_W-1:0] rs_d_ff [RCD_PATHS];
	logic signed [RCD_RS_W-1:0] out_d_ff [RCD_PATHS];

	for (genvar p = 0; p < RCD_PATHS; p++)
	begin : g_path // RQ21
		logic signed [RCD_IN_W-1:0] raw;
		logic signed [RCD_C2_W-1:0] i1_ff;
		logic signed [RCD_C2_W-1:0] i2_ff;
		logic signed [RCD_C2_W-1:0] d1_ff;
		logic signed [RCD_C2_W-1:0] d2_ff;
		logic signed [RCD_C2_W-1:0] c1;
		logic signed [RCD_C2_W-1:0] c2;
		logic signed [RCD_C2_W-1:0] byp;
		logic signed [RCD_C5_W-1:0] int5_ff [RCD_ORDER5];
		logic signed [RCD_C5_W-1:0] dly5_ff [RCD_ORDER5];
		logic signed [RCD_C5_W-1:0] cmb5 [RCD_ORDER5];

		assign raw = (p == 0) ? in_sample.i : in_sample.q;
		assign scaled[p] = raw >>> in_shift; // RQ18
		assign byp = RCD_C2_W'(scaled[p]);
		assign c1 = i2_ff - d1_ff;
		assign c2 = c1 - d2_ff;

		// second-order integrators at input rate, combs at output rate
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
			begin
				i1_ff <= '0;
				i2_ff <= '0;
				d1_ff <= '0;
				d2_ff <= '0;
				rs_d_ff[p] <= '0;
			end
			else if (in_valid) // RQ15
			begin
				i1_ff <= i1_ff + RCD_C2_W'(scaled[p]);
				i2_ff <= i2_ff + i1_ff;
				if (bypass)
				begin
					rs_d_ff[p] <= RCD_RS_W'(byp >>> coarse_shift); // RQ7
				end
				else if (emit)
				begin
					d1_ff <= i2_ff;
					d2_ff <= c1;
					rs_d_ff[p] <= RCD_RS_W'(c2 >>> coarse_shift);
				end
			end
		end

		always_comb
		begin
			cmb5[0] = int5_ff[RCD_ORDER5-1] - dly5_ff[0];
			for (int k = 1; k < RCD_ORDER5; k++)
			begin
				cmb5[k] = cmb5[k-1] - dly5_ff[k];
			end
		end

		always_ff @(posedge aclk)
		begin
			if (!aresetn)
			begin
				for (int k = 0; k < RCD_ORDER5; k++)
				begin
					int5_ff[k] <= '0;
					dly5_ff[k] <= '0;
				end
				out_d_ff[p] <= '0;
			end
			else if (rs_valid_ff)
			begin
				int5_ff[0] <= int5_ff[0] + RCD_C5_W'(rs_d_ff[p]); // RQ10
				for (int k = 1; k < RCD_ORDER5; k++)
				begin
					int5_ff[k] <= int5_ff[k] + int5_ff[k-1];
				end
				if (f5_dump)
				begin
					dly5_ff[0] <= int5_ff[RCD_ORDER5-1];
					for (int k = 1; k < RCD_ORDER5; k++)
					begin
						dly5_ff[k] <= cmb5[k-1];
					end
					out_d_ff[p] <= RCD_RS_W'(cmb5[RCD_ORDER5-1] >>> f5_shift); // RQ10
				end
			end
		end
	end

	assign out_sample.i = out_d_ff[0];
	assign out_sample.q = out_d_ff[1];

	a_bypass_rate: assert property (@(posedge aclk) disable iff (!aresetn) // RQ7
		bypass && in_valid |=> rs_valid_ff)
		else $error("bypass dropped a sample");
	a_bypass_scaled: assert property (@(posedge aclk) disable iff (!aresetn) // RQ18
		bypass && in_valid && scl_sel < 5'h8 |=> rs_d_ff[0] == RCD_RS_W'($past(scaled[0])))
		else $error("bypass value not scaled input");
	a_rs_needs_input: assert property (@(posedge aclk) disable iff (!aresetn) // RQ20
		rs_valid_ff |-> $past(in_valid))
		else $error("resample strobe without input");
	a_fifth_ratio: assert property (@(posedge aclk) disable iff (!aresetn) // RQ13
		out_valid |-> $past(rs_valid_ff) && $past(f5_cnt_ff) == $past(f5_m) - 6'h1)
		else $error("fifth stage output off count");
	a_fifth_range: assert property (@(posedge aclk) disable iff (!aresetn) // RQ9
		f5_m >= 6'h2 && f5_m <= 6'h20 && (f5_dec_ff inside {[6'h2:6'h20]} -> f5_m == f5_dec_ff))
		else $error("fifth decimation out of range");
	a_fifth_scale: assert property (@(posedge aclk) disable iff (!aresetn) // RQ11
		f5_shift <= 6'h19 && f5_shift >= 6'h5)
		else $error("fifth scale out of range");
	a_phase_bound: assert property (@(posedge aclk) disable iff (!aresetn) // RQ17
		rs_int_ff <= rs_dec_ff |-> phase_ff <= rs_dec_ff)
		else $error("resample phase overran");
	a_invert_exp: assert property (@(posedge aclk) disable iff (!aresetn) // RQ6
		rs_scl_ff[RCD_INV_BIT] && !rs_scl_ff[RCD_WEIGHT_BIT]
		|-> in_shift == 3'(3'h7 - in_exp + scl_sel[2:0]))
		else $error("inverted exponent shift wrong");
	a_weak_select: assert property (@(posedge aclk) disable iff (!aresetn) // RQ4
		!strong_sel_ff && !rs_scl_ff[RCD_INV_BIT] && !rs_scl_ff[RCD_WEIGHT_BIT]
		|-> in_shift == 3'(in_exp + rs_scl_ff[7:5]))
		else $error("weak scale not used");
endmodule // rcd_decimator
`default_nettype wire

//--- rcd_pkg.sv
// constants and carriers for the resampling comb decimator
`default_nettype none
package rcd_pkg;
	localparam int RCD_IN_W = 16;
	localparam int RCD_RS_W = 24;
	localparam int RCD_C2_W = 40;
	localparam int RCD_C5_W = 50;
	localparam int RCD_ORDER5 = 5;
	localparam int RCD_PATHS = 2;
	// register indices, byte address is four times the index
	localparam logic [9:0] RCD_IDX_RS_DEC = 10'h090;
	localparam logic [9:0] RCD_IDX_RS_INT = 10'h091;
	localparam logic [9:0] RCD_IDX_RS_SCL = 10'h092;
	localparam logic [9:0] RCD_IDX_F5_DEC = 10'h094;
	localparam logic [9:0] RCD_IDX_F5_SCL = 10'h095;
	localparam logic [9:0] RCD_IDX_CTRL = 10'h096;
	localparam logic [9:0] RCD_IDX_STAT = 10'h097;
	localparam int RCD_DEC_W = 12;
	localparam int RCD_INT_W = 9;
	localparam int RCD_SCL_W = 12;
	localparam int RCD_F5D_W = 6;
	localparam int RCD_F5S_W = 5;
	localparam int RCD_STRONG_LSB = 0;
	localparam int RCD_WEAK_LSB = 5;
	localparam int RCD_WEIGHT_BIT = 10;
	localparam int RCD_INV_BIT = 11;
	localparam logic [11:0] RCD_RS_DEC_RST = 12'h000;
	localparam logic [8:0] RCD_RS_INT_RST = 9'h000;
	localparam logic [11:0] RCD_RS_SCL_RST = 12'h000;
	localparam logic [5:0] RCD_F5_DEC_RST = 6'h02;
	localparam logic [4:0] RCD_F5_SCL_RST = 5'h00;
	localparam logic [5:0] RCD_F5_DEC_MIN = 6'h02;
	localparam logic [5:0] RCD_F5_DEC_MAX = 6'h20;
	localparam logic [4:0] RCD_F5_SCL_MAX = 5'h14;
	localparam logic [5:0] RCD_F5_SHIFT_OFS = 6'h05;
	localparam logic [2:0] RCD_EXP_MAX = 3'h7;
	localparam logic [1:0] RCD_RESP_OKAY = 2'h0;
	localparam logic [1:0] RCD_RESP_SLVERR = 2'h2;
	typedef struct packed {
		logic signed [RCD_IN_W-1:0] i;
		logic signed [RCD_IN_W-1:0] q;
	} rcd_in_iq_t;
	typedef struct packed {
		logic signed [RCD_RS_W-1:0] i;
		logic signed [RCD_RS_W-1:0] q;
	} rcd_out_iq_t;
endpackage
`default_nettype wire

//--- rcd_dummy_unused.sv
// intentionally empty
`default_nettype none
`default_nettype wire

//--- rcd_source.sv
// upstream sample source model feeding the comb decimator
`timescale 1ns/1ps
`default_nettype none
module rcd_source
	import rcd_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic en,
	input wire rcd_in_iq_t lvl,
	input wire logic [3:0] gap,
	output rcd_in_iq_t smp,
	output logic valid
);
	logic [3:0] cnt_ff;
	logic vld_ff;
	// one sample every gap+1 clocks, never faster than the clock
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !en)
		begin
			cnt_ff <= 4'h0;
			vld_ff <= 1'b0;
		end
		else
		begin
			vld_ff <= (cnt_ff == gap);
			cnt_ff <= (cnt_ff == gap) ? 4'h0 : cnt_ff + 4'h1;
		end
	end
	// lines carry a changed value between samples
	assign smp = vld_ff ? lvl : ~lvl;
	assign valid = vld_ff;
endmodule // rcd_source
`default_nettype wire

//--- tb.sv
// self-checking bench for the resampling comb decimator
`timescale 1ns/1ps
`default_nettype none
module tb
	import rcd_pkg::*;
;
	localparam int LVL = 1024;
	localparam logic [11:0] A_DEC = {RCD_IDX_RS_DEC, 2'b00};
	localparam logic [11:0] A_INT = {RCD_IDX_RS_INT, 2'b00};
	localparam logic [11:0] A_SCL = {RCD_IDX_RS_SCL, 2'b00};
	localparam logic [11:0] A_F5D = {RCD_IDX_F5_DEC, 2'b00};
	localparam logic [11:0] A_F5S = {RCD_IDX_F5_SCL, 2'b00};
	localparam logic [11:0] A_CTL = {RCD_IDX_CTRL, 2'b00};
	localparam logic [11:0] A_STA = {RCD_IDX_STAT, 2'b00};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, vld, out_v;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [2:0] exp_v = 3'h0;
	logic en = 1'b0;
	logic [3:0] gap = 4'h0;
	rcd_in_iq_t lvl = 32'h0400fc00;
	rcd_in_iq_t smp;
	rcd_out_iq_t out_s, last_s;
	int n_errors = 0;
	int n_compared = 0;
	int cyc = 0;
	int last = 0;
	int spc = 0;
	int n_out = 0;

	always #2 aclk = ~aclk;

	rcd_source src (.aclk(aclk), .aresetn(aresetn), .en(en), .lvl(lvl), .gap(gap),
		.smp(smp), .valid(vld));

	rcd_decimator dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .in_sample(smp), .in_exp(exp_v), .in_valid(vld),
		.out_sample(out_s), .out_valid(out_v));

	// output strobe spacing and last sample
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (out_v === 1'b1)
		begin
			spc <= cyc - last;
			last <= cyc;
			n_out <= n_out + 1;
			last_s <= out_s;
		end
	end

	task automatic give_verdict;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic fail(input string m);
		n_errors++;
		$display("[ERR] %0t %s", $time, m);
	endtask

	task automatic timeout;
		fail("no answer in time");
		give_verdict();
	endtask

	task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
			fail($sformatf("value %h want %h", g, e));
	endtask

	task automatic chk_smp(input rcd_out_iq_t g, input rcd_out_iq_t e);
		n_compared++;
		if (g !== e)
			fail($sformatf("sample %h want %h", g, e));
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw, tk;
		int n;
		tk = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 64 && !tk; n++)
		begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tk = bvalid;
			if (tk)
				chk_val({30'h0, bresp}, {30'h0, er});
			@(posedge aclk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
			if (tk)
				bready <= 1'b0;
		end
		if (!tk)
			timeout();
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ta, tk;
		int n;
		tk = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 64 && !tk; n++)
		begin
			@(negedge aclk);
			ta = arvalid && arready;
			tk = rvalid;
			if (tk)
			begin
				chk_val(rdata, ed);
				chk_val({30'h0, rresp}, {30'h0, er});
			end
			@(posedge aclk);
			if (ta)
				arvalid <= 1'b0;
			if (tk)
				rready <= 1'b0;
		end
		if (!tk)
			timeout();
	endtask

	// program both stages, let the filters settle, check spacing and level
	task automatic run(input logic [5:0] m5, input logic [4:0] s5, input logic [11:0] scl,
		input logic ctl, input logic [2:0] e, input logic [3:0] g, input int sh, input int sp);
		int n0;
		int n;
		wr(A_F5D, {26'h0, m5}, RCD_RESP_OKAY);
		wr(A_F5S, {27'h0, s5}, RCD_RESP_OKAY);
		wr(A_SCL, {20'h0, scl}, RCD_RESP_OKAY);
		wr(A_CTL, {31'h0, ctl}, RCD_RESP_OKAY);
		@(posedge aclk);
		exp_v <= e;
		gap <= g;
		n0 = n_out;
		for (n = 0; n < 5000 && n_out < n0 + 12; n++)
			@(posedge aclk);
		if (n_out < n0 + 12)
			timeout();
		chk_val(spc, sp);
		if (sh >= 0)
			chk_smp(last_s, {24'(LVL >>> sh), 24'(-(LVL >>> sh))});
	endtask

	initial
	begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rd(A_DEC, 32'h0, RCD_RESP_OKAY);
		rd(A_INT, 32'h0, RCD_RESP_OKAY);
		rd(A_SCL, 32'h0, RCD_RESP_OKAY);
		rd(A_F5D, 32'h2, RCD_RESP_OKAY);
		wr(A_DEC, 32'hffffffff, RCD_RESP_OKAY);
		rd(A_DEC, 32'h00000fff, RCD_RESP_OKAY);
		wr(A_INT, 32'hffffffff, RCD_RESP_OKAY);
		rd(A_INT, 32'h000001ff, RCD_RESP_OKAY);
		wr(A_SCL, 32'hffffffff, RCD_RESP_OKAY);
		rd(A_SCL, 32'h00000fff, RCD_RESP_OKAY);
		wr(12'h000, 32'h1, RCD_RESP_SLVERR);
		rd(12'h000, 32'h0, RCD_RESP_SLVERR);
		wr(A_STA, 32'hffff, RCD_RESP_OKAY);
		rd(A_STA, 32'h0, RCD_RESP_OKAY);
		wr(A_DEC, 32'h0, RCD_RESP_OKAY);
		wr(A_INT, 32'h0, RCD_RESP_OKAY);
		en <= 1'b1;
		run(6'h02, 5'h00, 12'h000, 1'b0, 3'h0, 4'h0, 0, 2);
		run(6'h20, 5'h14, 12'h000, 1'b0, 3'h0, 4'h0, 0, 32);
		run(6'h04, 5'h05, 12'h040, 1'b0, 3'h3, 4'h0, 5, 4);
		run(6'h04, 5'h05, 12'h840, 1'b0, 3'h3, 4'h0, 6, 4);
		run(6'h04, 5'h05, 12'h440, 1'b0, 3'h3, 4'h0, 0, 4);
		run(6'h04, 5'h05, 12'h041, 1'b1, 3'h0, 4'h0, 1, 4);
		run(6'h04, 5'h05, 12'h000, 1'b0, 3'h0, 4'h1, 0, 8);
		wr(A_DEC, 32'h3, RCD_RESP_OKAY);
		run(6'h02, 5'h00, 12'h000, 1'b0, 3'h0, 4'h0, -1, 8);
		wr(A_INT, 32'h1, RCD_RESP_OKAY);
		run(6'h02, 5'h00, 12'h000, 1'b0, 3'h0, 4'h0, -1, 4);
		give_verdict();
	end
endmodule // tb
`default_nettype wire
